// *** shared/pswc_pkg.sv ***
// pswc_pkg: register map, field positions, reset values, timing constants
// assumes: 100 MHz system clock, APB with 32-bit data
package pswc_pkg;
    // ==========================================================
    // register indices (printed offsets are not all word aligned)
    localparam logic [7:0] IDX_SLEEP_COMMAND = 8'h12;
    localparam logic [7:0] IDX_SLOW_CLOCK_ENABLE = 8'h2A;
    localparam logic [7:0] IDX_TIME_BASE_SELECT = 8'h2B;
    localparam logic [7:0] IDX_STROBE_GLOBAL_CONTROL = 8'h2C;
    localparam logic [7:0] IDX_PORT_B_STROBE_ENABLE = 8'h2D;
    localparam logic [7:0] IDX_PORT_C_STROBE_ENABLE = 8'h2E;
    localparam logic [7:0] IDX_PORT_D_STROBE_ENABLE = 8'h2F;
    localparam logic [7:0] IDX_WAKE_SOURCE_ENABLE = 8'h30;
    localparam logic [7:0] IDX_WAKE_EVENT_STATUS = 8'h31;
    localparam logic [7:0] IDX_DISPLAY_POWER_CONTROL = 8'h32;
    localparam logic [7:0] IDX_PORT_B_WAKE_MASK = 8'h37;
    localparam logic [7:0] IDX_PORT_C_WAKE_MASK = 8'h38;
    localparam logic [7:0] IDX_PORT_D_WAKE_MASK = 8'h39;
    // ==========================================================
    // command and field layout
    localparam logic [7:0] SLEEP_COMMAND_CONSTANT = 8'hAA;
    localparam int SLOW_CLOCK_SRC_ENABLE_BIT = 7;
    localparam int STRONG_DRIVE_BIT = 4;
    localparam int GREEN_ENABLE_BIT = 4;
    localparam int KEY_WAKE_BIT = 0;
    localparam int SLOW_TICK_WAKE_BIT = 1;
    localparam int FAST_TICK_WAKE_BIT = 3;
    localparam logic [7:0] TIME_BASE_SELECT_MASK = 8'h1F;
    localparam logic [7:0] STROBE_GLOBAL_MASK = 8'h01;
    localparam logic [7:0] PORT_B_MASK = 8'h07;
    localparam logic [7:0] PORT_C_MASK = 8'hFF;
    localparam logic [7:0] PORT_D_MASK = 8'hAF;
    localparam logic [7:0] WAKE_MASK = 8'h0B;
    localparam logic [7:0] DISPLAY_POWER_MASK = 8'h1F;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] SLOW_CLOCK_ENABLE_RESET = 8'h80;
    // ==========================================================
    // timing
    localparam int CLOCK_HZ = 100000000;
    localparam int WAKE_STALL_CYCLES = 16384;
    localparam int SLOW_SOURCE_HZ = 32768;
    localparam int STRONG_SHORT_SEC = 2;
    localparam int STRONG_LONG_SEC = 4;
    localparam int STROBE_PERIOD_NS = 1000;
    localparam int STROBE_CYCLES = (STROBE_PERIOD_NS * (CLOCK_HZ / 1000000)) / 1000;
    // fast and slow tick dividers in 32 kHz periods
    localparam logic [14:0] DIV_128HZ = 15'd256;
    localparam logic [14:0] DIV_512HZ = 15'd64;
    localparam logic [14:0] DIV_256HZ = 15'd128;
    localparam logic [14:0] DIV_1KHZ = 15'd32;
    localparam logic [14:0] DIV_2HZ = 15'd16384;
    localparam logic [14:0] DIV_8HZ = 15'd4096;
    localparam logic [14:0] DIV_4HZ = 15'd8192;
    localparam logic [14:0] DIV_16HZ = 15'd2048;
    // ==========================================================
    // display modes and power states
    typedef enum logic [1:0] {
        DISP_NORMAL = 2'h0,
        DISP_ALL_ON = 2'h1,
        DISP_ALL_OFF = 2'h2,
        DISP_OFF = 2'h3
    } pswc_disp_type;
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_SLEEP = 5'h02,
        ST_HALT = 5'h04,
        ST_GREEN = 5'h08,
        ST_STALL = 5'h10
    } pswc_state_type;
endpackage

// *** logic/pswc_stall_counter.sv ***
// pswc_stall_counter: counts the post-wake stall on the restarted clock
// assumes: start is a one-cycle pulse; counting only while clock runs
`timescale 1ns/1ps
`default_nettype none
module pswc_stall_counter #(
    parameter int CYCLES = 16384
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic start,
    output logic done
);
    import pswc_pkg::*;
    typedef struct packed {
        logic [15:0] cnt;
        logic run;
    } pswc_cnt_type;
    pswc_cnt_type s_r, s_nxt;
    // ==========================================================
    // count the stall, pulse done at completion
    always_comb begin
        s_nxt = s_r;
        if (start) begin
            s_nxt.cnt = 16'h0000;
            s_nxt.run = 1'b1;
        end else if (s_r.run) begin
            if (s_r.cnt == 16'(CYCLES - 1)) begin
                s_nxt.run = 1'b0;
            end
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign done = s_r.run && (s_r.cnt == 16'(CYCLES - 1));
endmodule
`default_nettype wire

// *** logic/pswc_tick_gen.sv ***
// pswc_tick_gen: 32 kHz time base with fast and slow wake ticks
// assumes: src_tick is a one-cycle enable at 32768 Hz from the oscillator
`timescale 1ns/1ps
`default_nettype none
module pswc_tick_gen (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // time base
    input wire logic src_tick,
    input wire logic enable,
    input wire logic clear,
    input wire logic [1:0] fast_sel,
    input wire logic [1:0] slow_sel,
    output logic fast_tick,
    output logic slow_tick
);
    import pswc_pkg::*;
    typedef struct packed {
        logic [14:0] cnt;
        logic fast;
        logic slow;
    } pswc_tick_type;
    pswc_tick_type s_r, s_nxt;
    logic [14:0] fast_div, slow_div;
    function automatic logic [14:0] div_mask(input logic [14:0] d);
        div_mask = d - 15'd1;
    endfunction
    // ==========================================================
    // rate decode
    always_comb begin
        case (fast_sel)
            2'h0: fast_div = DIV_128HZ;
            2'h1: fast_div = DIV_512HZ;
            2'h2: fast_div = DIV_256HZ;
            default: fast_div = DIV_1KHZ;
        endcase
        case (slow_sel)
            2'h0: slow_div = DIV_2HZ;
            2'h1: slow_div = DIV_8HZ;
            2'h2: slow_div = DIV_4HZ;
            default: slow_div = DIV_16HZ;
        endcase
    end
    // counter, ticks at mask rollover
    always_comb begin
        s_nxt = s_r;
        s_nxt.fast = 1'b0;
        s_nxt.slow = 1'b0;
        if (clear || !enable) begin
            s_nxt.cnt = 15'h0000;
        end else if (src_tick) begin
            s_nxt.cnt = s_r.cnt + 15'h0001;
            s_nxt.fast = (s_r.cnt & div_mask(fast_div)) == div_mask(fast_div);
            s_nxt.slow = (s_r.cnt & div_mask(slow_div)) == div_mask(slow_div);
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign fast_tick = s_r.fast;
    assign slow_tick = s_r.slow;
endmodule
`default_nettype wire

// *** logic/pswc_power_ctrl.sv ***
// pswc_power_ctrl: sleep, halt and green mode control with key and tick wake
// assumes: APB master; key pads and strobe point are synchronous inputs
//
// Summary of operation
// - command AAh sleeps, other value resets
// - sleep stops all clocks and generator
// - sleep disables LOW_VOLTAGE_RESET, holds RAM, pins
// - enabled key pin change wakes device
// - stall CPU 16384 cycles after wake
// - halt/green keep 32k and LCD running
// - green bit selects green or halt
// - 32k enable default on, read clears
// - display mode field decode, reset 00
// - flags set on event, cleared by enable
// - fast tick select 128/512/256/1k Hz
// - slow tick select 2/8/4/16 Hz
// - strong drive 2 s or 4 s
// - strobe sampling of keys at strobe points
// - per-pin strobe enables, reset zero
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pswc_power_ctrl (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // key pads and time base
    input wire logic [2:0] port_b_in,
    input wire logic [7:0] port_c_in,
    input wire logic [7:0] port_d_in,
    input wire logic strobe_point,
    input wire logic slow_src_tick,
    // power outputs
    output logic sys_clock_run,
    output logic clock_gen_run,
    output logic slow_clock_run,
    output logic display_driver_on,
    output logic display_green,
    output logic [1:0] display_mode_field,
    output logic [1:0] display_bias_field,
    output logic low_voltage_reset_enable,
    output logic io_hold,
    output logic cpu_stall,
    output logic system_reset_req,
    output logic strong_drive_long
);
    import pswc_pkg::*;
    typedef struct packed {
        pswc_state_type st;
        logic [7:0] slow_en;
        logic [7:0] tbs;
        logic [7:0] strobe_g;
        logic [7:0] strobe_b;
        logic [7:0] strobe_c;
        logic [7:0] strobe_d;
        logic [7:0] wake_en;
        logic [7:0] wake_flag;
        logic [7:0] disp;
        logic [7:0] wk_b;
        logic [7:0] wk_c;
        logic [7:0] wk_d;
        logic [18:0] key_last;
        logic [31:0] rdata;
        logic rst_req;
    } pswc_state_reg_type;
    pswc_state_reg_type s_r, s_nxt;
    logic wr_acc, rd_acc, stall_start, stall_done, fast_tick, slow_tick, tick_clear;
    logic [18:0] key_now, key_mask, strobe_mask, key_change;
    logic key_event, is_sleeping;
    // ==========================================================
    // bus decode
    function automatic logic [7:0] reg_index(input logic [11:0] a);
        reg_index = a[9:2];
    endfunction
    function automatic logic is_mapped(input logic [7:0] i);
        case (i)
            IDX_SLEEP_COMMAND, IDX_SLOW_CLOCK_ENABLE, IDX_TIME_BASE_SELECT,
            IDX_STROBE_GLOBAL_CONTROL, IDX_PORT_B_STROBE_ENABLE, IDX_PORT_C_STROBE_ENABLE,
            IDX_PORT_D_STROBE_ENABLE, IDX_WAKE_SOURCE_ENABLE, IDX_WAKE_EVENT_STATUS,
            IDX_DISPLAY_POWER_CONTROL, IDX_PORT_B_WAKE_MASK, IDX_PORT_C_WAKE_MASK,
            IDX_PORT_D_WAKE_MASK: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction
    // single cycle access phase; unmapped or misaligned gives pslverr
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!is_mapped(reg_index(paddr)) || (paddr[1:0] != 2'h0) ||
                     (paddr[11:10] != 2'h0));
    // ==========================================================
    // key sampling and strobe gating
    assign key_now = {port_d_in, port_c_in, port_b_in};
    assign key_mask = {s_r.wk_d & PORT_D_MASK, s_r.wk_c, s_r.wk_b[2:0]};
    assign strobe_mask = {s_r.strobe_d, s_r.strobe_c, s_r.strobe_b[2:0]};
    // strobed pins are only looked at on a strobe point
    genvar gi;
    generate
        for (gi = 0; gi < 19; gi++) begin : g_key
            assign key_change[gi] = key_mask[gi] && (key_now[gi] != s_r.key_last[gi]) &&
                                    (!s_r.strobe_g[0] || !strobe_mask[gi] || strobe_point);
        end
    endgenerate
    assign key_event = (|key_change) && s_r.wake_en[KEY_WAKE_BIT];
    assign is_sleeping = (s_r.st == ST_SLEEP) || (s_r.st == ST_HALT) || (s_r.st == ST_GREEN);
    assign tick_clear = rd_acc && (reg_index(paddr) == IDX_SLOW_CLOCK_ENABLE);
    // ==========================================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.rst_req = 1'b0;
        stall_start = 1'b0;
        // key reference tracks pins only when sampled
        for (int i = 0; i < 19; i++) begin
            if (!s_r.strobe_g[0] || !strobe_mask[i] || strobe_point) begin
                s_nxt.key_last[i] = key_now[i];
            end
        end
        // register writes
        if (wr_acc && !pslverr) begin
            case (reg_index(paddr))
                IDX_SLEEP_COMMAND: begin
                    if (pwdata[7:0] == SLEEP_COMMAND_CONSTANT) begin
                        if (s_r.disp[1:0] != DISP_OFF) begin
                            s_nxt.st = s_r.disp[GREEN_ENABLE_BIT] ? ST_GREEN : ST_HALT;
                        end else begin
                            s_nxt.st = ST_SLEEP;
                        end
                    end else begin
                        s_nxt.rst_req = 1'b1;
                    end
                end
                IDX_SLOW_CLOCK_ENABLE: s_nxt.slow_en = pwdata[7:0] & SLOW_CLOCK_ENABLE_RESET;
                IDX_TIME_BASE_SELECT: s_nxt.tbs = pwdata[7:0] & TIME_BASE_SELECT_MASK;
                IDX_STROBE_GLOBAL_CONTROL: s_nxt.strobe_g = pwdata[7:0] & STROBE_GLOBAL_MASK;
                IDX_PORT_B_STROBE_ENABLE: s_nxt.strobe_b = pwdata[7:0] & PORT_B_MASK;
                IDX_PORT_C_STROBE_ENABLE: s_nxt.strobe_c = pwdata[7:0] & PORT_C_MASK;
                IDX_PORT_D_STROBE_ENABLE: s_nxt.strobe_d = pwdata[7:0] & PORT_D_MASK;
                IDX_WAKE_SOURCE_ENABLE: s_nxt.wake_en = pwdata[7:0] & WAKE_MASK;
                IDX_DISPLAY_POWER_CONTROL: s_nxt.disp = pwdata[7:0] & DISPLAY_POWER_MASK;
                IDX_PORT_B_WAKE_MASK: s_nxt.wk_b = pwdata[7:0] & PORT_B_MASK;
                IDX_PORT_C_WAKE_MASK: s_nxt.wk_c = pwdata[7:0] & PORT_C_MASK;
                IDX_PORT_D_WAKE_MASK: s_nxt.wk_d = pwdata[7:0] & PORT_D_MASK;
                default: s_nxt.rst_req = s_nxt.rst_req;
            endcase
        end
        // flags clear with their enable, events win over the clear
        s_nxt.wake_flag = s_r.wake_flag & s_nxt.wake_en;
        if (key_event) begin
            s_nxt.wake_flag[KEY_WAKE_BIT] = 1'b1;
        end
        if (slow_tick && s_r.wake_en[SLOW_TICK_WAKE_BIT]) begin
            s_nxt.wake_flag[SLOW_TICK_WAKE_BIT] = 1'b1;
        end
        if (fast_tick && s_r.wake_en[FAST_TICK_WAKE_BIT]) begin
            s_nxt.wake_flag[FAST_TICK_WAKE_BIT] = 1'b1;
        end
        // power state sequence
        case (s_r.st)
            ST_RUN: s_nxt.st = s_nxt.st;
            ST_SLEEP, ST_HALT, ST_GREEN: begin
                if (key_event || (slow_tick && s_r.wake_en[SLOW_TICK_WAKE_BIT]) ||
                    (fast_tick && s_r.wake_en[FAST_TICK_WAKE_BIT])) begin
                    s_nxt.st = ST_STALL;
                    stall_start = 1'b1;
                end
            end
            ST_STALL: begin
                if (stall_done) begin
                    s_nxt.st = ST_RUN;
                end
            end
            default: s_nxt.st = ST_RUN;
        endcase
        // read data latched on the setup edge so it stands through the access phase
        if (psel && !penable && !pwrite) begin
            case (reg_index(paddr))
                IDX_SLOW_CLOCK_ENABLE: s_nxt.rdata = {24'h000000, s_r.slow_en};
                IDX_TIME_BASE_SELECT: s_nxt.rdata = {24'h000000, s_r.tbs};
                IDX_STROBE_GLOBAL_CONTROL: s_nxt.rdata = {24'h000000, s_r.strobe_g};
                IDX_PORT_B_STROBE_ENABLE: s_nxt.rdata = {24'h000000, s_r.strobe_b};
                IDX_PORT_C_STROBE_ENABLE: s_nxt.rdata = {24'h000000, s_r.strobe_c};
                IDX_PORT_D_STROBE_ENABLE: s_nxt.rdata = {24'h000000, s_r.strobe_d};
                IDX_WAKE_SOURCE_ENABLE: s_nxt.rdata = {24'h000000, s_r.wake_en};
                IDX_WAKE_EVENT_STATUS: s_nxt.rdata = {24'h000000, s_r.wake_flag};
                IDX_DISPLAY_POWER_CONTROL: s_nxt.rdata = {24'h000000, s_r.disp};
                IDX_PORT_B_WAKE_MASK: s_nxt.rdata = {24'h000000, s_r.wk_b};
                IDX_PORT_C_WAKE_MASK: s_nxt.rdata = {24'h000000, s_r.wk_c};
                IDX_PORT_D_WAKE_MASK: s_nxt.rdata = {24'h000000, s_r.wk_d};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
    end
    // ==========================================================
    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= ST_RUN;
            s_r.slow_en <= SLOW_CLOCK_ENABLE_RESET;
            s_r.tbs <= RESET_ZERO;
            s_r.disp <= RESET_ZERO;
        end else begin
            s_r <= s_nxt;
        end
    end
    // ==========================================================
    // sub blocks
    pswc_tick_gen u_tick (
        .clock(clock),
        .rst_n(rst_n),
        .src_tick(slow_src_tick),
        .enable(s_r.slow_en[SLOW_CLOCK_SRC_ENABLE_BIT] && (s_r.st != ST_SLEEP)),
        .clear(tick_clear),
        .fast_sel(s_r.tbs[1:0]),
        .slow_sel(s_r.tbs[3:2]),
        .fast_tick(fast_tick),
        .slow_tick(slow_tick)
    );
    pswc_stall_counter #(.CYCLES(WAKE_STALL_CYCLES)) u_stall (
        .clock(clock),
        .rst_n(rst_n),
        .start(stall_start),
        .done(stall_done)
    );
    // ==========================================================
    // outputs
    assign prdata = s_r.rdata;
    assign system_reset_req = s_r.rst_req;
    assign sys_clock_run = !is_sleeping;
    assign clock_gen_run = (s_r.st != ST_SLEEP);
    assign slow_clock_run = s_r.slow_en[SLOW_CLOCK_SRC_ENABLE_BIT] && (s_r.st != ST_SLEEP);
    assign display_driver_on = (s_r.st != ST_SLEEP) && (s_r.disp[1:0] != DISP_OFF);
    assign display_green = (s_r.st == ST_GREEN);
    assign display_mode_field = s_r.disp[1:0];
    assign display_bias_field = s_r.disp[3:2];
    assign low_voltage_reset_enable = !is_sleeping;
    assign io_hold = is_sleeping;
    assign cpu_stall = is_sleeping || (s_r.st == ST_STALL);
    assign strong_drive_long = s_r.tbs[STRONG_DRIVE_BIT];
    // ==========================================================
    // checks
    chk_cmd_sleep: assert property (@(posedge clock) disable iff (!rst_n)
        (s_r.st == ST_RUN && wr_acc && !pslverr && reg_index(paddr) == IDX_SLEEP_COMMAND &&
         pwdata[7:0] == SLEEP_COMMAND_CONSTANT) |=> is_sleeping)
        else $error("sleep command did not sleep");
    chk_cmd_reset: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_acc && !pslverr && reg_index(paddr) == IDX_SLEEP_COMMAND &&
         pwdata[7:0] != SLEEP_COMMAND_CONSTANT) |=> system_reset_req)
        else $error("bad sleep value gave no reset");
    chk_clock_stop: assert property (@(posedge clock) disable iff (!rst_n)
        (s_r.st == ST_SLEEP) |-> (!sys_clock_run && !clock_gen_run && !slow_clock_run))
        else $error("clock running in sleep");
    chk_lvr_off: assert property (@(posedge clock) disable iff (!rst_n)
        is_sleeping |-> (!low_voltage_reset_enable && io_hold))
        else $error("lvr or io not held in sleep");
    chk_stall_len: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(s_r.st == ST_STALL) |-> cpu_stall [*8])
        else $error("stall released early");
    chk_stall_end: assert property (@(posedge clock) disable iff (!rst_n)
        (s_r.st == ST_STALL && stall_done) |=> !cpu_stall)
        else $error("stall not released");
    chk_flag_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (!s_r.wake_en[KEY_WAKE_BIT] && !$past(key_event)) |-> !s_r.wake_flag[KEY_WAKE_BIT])
        else $error("key flag set without enable");
    chk_halt_lcd: assert property (@(posedge clock) disable iff (!rst_n)
        (s_r.st == ST_HALT || s_r.st == ST_GREEN) |-> display_driver_on)
        else $error("lcd off in halt or green");
    chk_strobe_gate: assert property (@(posedge clock) disable iff (!rst_n)
        (s_r.strobe_g[0] && !strobe_point) |-> ((key_change & strobe_mask) == 19'h00000))
        else $error("strobed key seen off strobe point");
    chk_tick_wake: assert property (@(posedge clock) disable iff (!rst_n)
        (s_r.st == ST_HALT && fast_tick && s_r.wake_en[FAST_TICK_WAKE_BIT]) |=> (s_r.st == ST_STALL))
        else $error("fast tick did not wake halt");
    cov_strobe_wake: cover property (@(posedge clock) key_event && s_r.strobe_g[0]);
    cov_sleep: cover property (@(posedge clock) s_r.st == ST_SLEEP);
    cov_green: cover property (@(posedge clock) s_r.st == ST_GREEN);
    cov_wake: cover property (@(posedge clock) $fell(s_r.st == ST_STALL));
endmodule
`default_nettype wire

// *** verif/pswc_keypad_model.sv ***
// pswc_keypad_model: keypad keys on the key pads, plus strobe point and slow source pulses
// assumes: keys idle high through pull-ups; press() is called off the clock edge
`timescale 1ns/1ps
`default_nettype none
module pswc_keypad_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pads and time base
    output logic [2:0] port_b_in,
    output logic [7:0] port_c_in,
    output logic [7:0] port_d_in,
    output logic strobe_point,
    output logic slow_src_tick
);
    logic [3:0] div_r;
    // ==========================================================
    // strobe point and slow source pulses, one cycle each
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 4'h0;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end
    assign strobe_point = (div_r == 4'hF);
    assign slow_src_tick = div_r[2:0] == 3'h7;
    // ==========================================================
    // keys idle at the pull-up level
    initial begin
        port_b_in = 3'h7;
        port_c_in = 8'hFF;
        port_d_in = 8'hFF;
    end
    // a key press flips one port b pad at the next edge
    task automatic press(input int bit_n);
        @(posedge clock);
        port_b_in[bit_n] <= ~port_b_in[bit_n];
    endtask
endmodule
`default_nettype wire

// *** verif/pswc_power_ctrl_test.sv ***
// pswc_power_ctrl_test: self-checking bench for the power save controller
// assumes: apb slave always ready; read data valid in the access phase
`timescale 1ns/1ps
`default_nettype none
module pswc_power_ctrl_test;
    import pswc_pkg::*;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, sys_clock_run, clock_gen_run, slow_clock_run, display_driver_on, display_green;
    logic low_voltage_reset_enable, io_hold, cpu_stall, system_reset_req, strong_drive_long, strobe_point, slow_src_tick;
    logic [1:0] display_mode_field, display_bias_field;
    logic [2:0] port_b_in;
    logic [7:0] port_c_in, port_d_in;
    logic [7:0] idx_t [8] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h32};
    logic [7:0] msk_t [8] = '{8'h80, 8'h1F, 8'h01, 8'h07, 8'hFF, 8'hAF, 8'h0B, 8'h1F};
    logic [7:0] wv;
    int error_cnt = 0, checked = 0, n, seed;
    // ==========================================================
    // clock and instances
    always #5 clock = ~clock;
    pswc_power_ctrl i_pswc_power_ctrl (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_b_in(port_b_in), .port_c_in(port_c_in), .port_d_in(port_d_in), .strobe_point(strobe_point),
        .slow_src_tick(slow_src_tick), .sys_clock_run(sys_clock_run), .clock_gen_run(clock_gen_run),
        .slow_clock_run(slow_clock_run), .display_driver_on(display_driver_on), .display_green(display_green),
        .display_mode_field(display_mode_field), .display_bias_field(display_bias_field),
        .low_voltage_reset_enable(low_voltage_reset_enable), .io_hold(io_hold), .cpu_stall(cpu_stall),
        .system_reset_req(system_reset_req), .strong_drive_long(strong_drive_long));
    pswc_keypad_model i_pswc_keypad_model (.clock(clock), .rst_n(rst_n), .port_b_in(port_b_in),
        .port_c_in(port_c_in), .port_d_in(port_d_in), .strobe_point(strobe_point), .slow_src_tick(slow_src_tick));
    // ==========================================================
    // verdict and comparison
    task automatic conclude;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; response and read data taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            conclude();
        end
    endtask
    // sleep with the given display setting and wake source, then cpu_stall must release only after the full stall that follows the wake
    task automatic sleep_and_wake(input logic [7:0] disp, input logic [7:0] wen, input logic exp_lcd,
        input logic exp_green);
        apb(1'b1, IDX_DISPLAY_POWER_CONTROL, {24'h0, disp});
        apb(1'b1, IDX_WAKE_SOURCE_ENABLE, {24'h0, wen});
        // reading restarts the time base, so no tick lands before the checks below
        apb(1'b0, IDX_SLOW_CLOCK_ENABLE, 32'h0);
        compare(rd, 32'h80);
        apb(1'b1, IDX_SLEEP_COMMAND, 32'hAA);
        repeat (2) @(posedge clock);
        #1 compare({sys_clock_run, cpu_stall, low_voltage_reset_enable, io_hold}, 4'b0101);
        compare(clock_gen_run, exp_lcd);
        compare({display_driver_on, slow_clock_run, display_green}, {exp_lcd, exp_lcd, exp_green});
        if (wen[KEY_WAKE_BIT]) i_pswc_keypad_model.press(0);
        n = 0;
        while (cpu_stall !== 1'b0 && n < 20000) begin
            @(posedge clock);
            #1 n++;
        end
        compare(n >= WAKE_STALL_CYCLES && n < 20000, 1'b1);
        apb(1'b0, IDX_WAKE_EVENT_STATUS, 32'h0);
        compare(rd, {24'h0, wen});
        apb(1'b1, IDX_WAKE_SOURCE_ENABLE, 32'h00);
        apb(1'b0, IDX_WAKE_EVENT_STATUS, 32'h0);
        compare(rd, 32'h00);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        seed = $urandom(34558);
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, idx_t[i], 32'h0);
            compare(rd, (i == 0) ? 32'h80 : 32'h00);
        end
        for (int i = 0; i < 8; i++) begin
            wv = 8'($urandom);
            apb(1'b1, idx_t[i], {24'($urandom), wv});
            apb(1'b0, idx_t[i], 32'h0);
            compare(rd, {24'h0, wv & msk_t[i]});
            if (idx_t[i] == 8'h32) compare({display_bias_field, display_mode_field}, wv[3:0]);
            if (idx_t[i] == 8'h2B) compare(strong_drive_long, wv[4]);
        end
        for (int i = 0; i < 8; i++) apb(1'b1, idx_t[i], (i == 0) ? 32'h80 : 32'h00);
        apb(1'b0, 8'h40, 32'h0);
        compare(err, 1'b1);
        apb(1'b1, IDX_PORT_B_WAKE_MASK, 32'h07);
        sleep_and_wake(8'h03, 8'h01, 1'b0, 1'b0);
        apb(1'b1, IDX_STROBE_GLOBAL_CONTROL, 32'h01);
        apb(1'b1, IDX_PORT_B_STROBE_ENABLE, 32'h07);
        sleep_and_wake(8'h10, 8'h01, 1'b1, 1'b1);
        sleep_and_wake(8'h00, 8'h01, 1'b1, 1'b0);
        apb(1'b1, IDX_TIME_BASE_SELECT, 32'h03);
        sleep_and_wake(8'h00, 8'h08, 1'b1, 1'b0);
        apb(1'b1, IDX_SLEEP_COMMAND, 32'h55);
        #1 compare(system_reset_req, 1'b1);
        @(posedge clock);
        #1 compare(system_reset_req, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
